// ===== dca_host.sv
/* host model issuing register writes.
   assumes callers run on clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module dca_host (
    // clock
    input wire logic             clk_sys,
    // write port
    output logic                 reg_wr_en,
    output dca_pkg::dca_reg_wr_t reg_wr
);
    // idle port
    initial begin
        reg_wr_en = 1'b0;
        reg_wr    = '0;
    end
    // seven address bits, nine data bits, then scramble the lines
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_wr    <= {a, d};
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_wr    <= ~{a, d};
    endtask
endmodule
`default_nettype wire

// ===== dca_mix_atten.sv
/*
 * Routing and digital attenuation for three stereo pairs (six channels).
 * Each sample frame is routed per pair, attenuated per channel and handed
 * on to the interpolation filter one clock later.
 * Assumes register writes and sample frames come from logic on clk_sys,
 * one write and at most one frame per cycle.
 */
//
// Contract
// - a four-bit routing field sits at bits 8:5 of the control register, reset 1001.
// - low routing bits pick the left output, high bits the right: mute, left, right, average.
// - each channel's attenuation is applied to its samples before the filter.
// - each channel's attenuation is an eight-bit code, 0 to 127 dB cut in 0.5 dB steps.
// - after reset all channel codes and the all-channel code are all ones.
// - every channel attenuation register has a holding latch apart from the active value.
// - a write with bit 8 clear loads only the holding latch and leaves outputs unchanged; while commit_pend_reg is set, the next sample applies it.
// - a write with bit 8 set stores its value and commits all six holding latches from the next sample.
// - the commit flag is never stored and reads back as zero.
// - a write to address 0001000 loads its value into all six holding latches.
// - the last write to a channel or the all-channel register decides each holding latch.
// - channel codes sit at addresses 0, 1, 4, 5, 6 and 7.
// - code 00 mutes, 01 cuts 127 dB, each step up cuts 0.5 dB less, FF is unity.
// - with the sharing bit 3 set, each right channel uses its pair's left code from the next sample.
`timescale 1ns/1ps
`default_nettype none

module dca_mix_atten (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    // register write port, decoded from the serial control port
    input  wire logic               reg_wr_en,
    input  wire dca_pkg::dca_reg_wr_t reg_wr,
    // register read port, answer one cycle later
    input  wire logic [6:0]         reg_rd_addr,
    output logic [8:0]              reg_rd_data,
    // sample frame from the audio interface
    input  wire logic               smp_in_valid,
    input  wire dca_pkg::dca_frame_t smp_in,
    // sample frame towards the interpolation filter
    output logic                    smp_out_valid,
    output dca_pkg::dca_frame_t     smp_out
);

    // map a register address to a channel index, bit 3 marks a hit
    function automatic logic [3:0] att_index(input logic [6:0] addr);
        logic [3:0] res;
        res = 4'h0;
        case (addr)
            dca_pkg::DCA_ADDR_ATT_L0: res = 4'h8;
            dca_pkg::DCA_ADDR_ATT_R0: res = 4'h9;
            dca_pkg::DCA_ADDR_ATT_L1: res = 4'hA;
            dca_pkg::DCA_ADDR_ATT_R1: res = 4'hB;
            dca_pkg::DCA_ADDR_ATT_L2: res = 4'hC;
            dca_pkg::DCA_ADDR_ATT_R2: res = 4'hD;
            default:                  res = 4'h0;
        endcase
        return res;
    endfunction

    // pick one side's source; the average keeps the carry then halves
    function automatic dca_pkg::dca_smp_t route_pick(
        input logic [1:0]        sel,
        input dca_pkg::dca_smp_t lft,
        input dca_pkg::dca_smp_t rgt
    );
        logic signed [24:0] sum;
        dca_pkg::dca_smp_t  res;
        sum = 25'(lft) + 25'(rgt);
        case (dca_pkg::dca_route_t'(sel))
            dca_pkg::DCA_ROUTE_LEFT:  res = lft;
            dca_pkg::DCA_ROUTE_RIGHT: res = rgt;
            dca_pkg::DCA_ROUTE_AVG:   res = sum[24:1];
            default:                  res = 24'h000000;
        endcase
        return res;
    endfunction

    // scale a sample by an attenuation code
    function automatic dca_pkg::dca_smp_t att_apply(
        input dca_pkg::dca_smp_t smp,
        input dca_pkg::dca_att_t code
    );
        logic [7:0]         steps;
        logic [7:0]         whole;
        logic [7:0]         frac;
        logic signed [40:0] prod;
        logic signed [40:0] scaled;
        logic [5:0]         shamt;
        dca_pkg::dca_smp_t  res;
        steps  = dca_pkg::DCA_ATT_RESET - code;
        whole  = steps / dca_pkg::DCA_STEPS_PER_SHIFT;
        frac   = steps % dca_pkg::DCA_STEPS_PER_SHIFT;
        prod   = 41'(smp) * $signed({1'b0, dca_pkg::DCA_STEP_GAIN[frac[3:0]]});
        shamt  = 6'(dca_pkg::DCA_GAIN_FRAC) + whole[5:0];
        scaled = prod >>> shamt;
        res    = scaled[23:0];
        if (code == dca_pkg::DCA_ATT_MUTE) begin
            res = 24'h000000;
        end
        return res;
    endfunction

    // register state
    logic [8:0]               ctrl_reg;
    dca_pkg::dca_att_t        att_all_reg;
    dca_pkg::dca_att_t [5:0]  att_hold_reg;
    dca_pkg::dca_att_t [5:0]  att_act_reg;
    logic                     commit_pend_reg;
    logic [8:0]               rd_data_reg;
    logic                     out_valid_reg;
    dca_pkg::dca_frame_t      out_frame_reg;

    // write decode
    logic [3:0]               wr_idx;
    logic                     wr_chan;
    logic                     wr_all;
    logic                     wr_commit;
    logic [3:0]               rd_idx;
    dca_pkg::dca_att_t [5:0]  att_now;
    dca_pkg::dca_att_t [5:0]  att_use;
    logic [3:0]               route_sel;
    logic                     share_left;

    assign wr_idx    = att_index(reg_wr.addr);
    assign wr_chan   = reg_wr_en & wr_idx[3];
    assign wr_all    = reg_wr_en & (reg_wr.addr == dca_pkg::DCA_ADDR_ATT_ALL);
    assign wr_commit = (wr_chan | wr_all) & reg_wr.data[dca_pkg::DCA_COMMIT_BIT];
    assign rd_idx    = att_index(reg_rd_addr);

    // control register, only routing and sharing steer this block
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= dca_pkg::DCA_CTRL_RESET;
        end else if (reg_wr_en && reg_wr.addr == dca_pkg::DCA_ADDR_CTRL) begin
            ctrl_reg <= reg_wr.data;
        end
    end

    assign route_sel  = ctrl_reg[dca_pkg::DCA_ROUTE_MSB:dca_pkg::DCA_ROUTE_LSB];
    assign share_left = ctrl_reg[dca_pkg::DCA_ATC_BIT];

    // holding latches, last write of any kind wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            att_hold_reg <= {6{dca_pkg::DCA_ATT_RESET}};
            att_all_reg  <= dca_pkg::DCA_ATT_RESET;
        end else if (wr_all) begin
            att_hold_reg <= {6{reg_wr.data[7:0]}};
            att_all_reg  <= reg_wr.data[7:0];
        end else if (wr_chan) begin
            att_hold_reg[wr_idx[2:0]] <= reg_wr.data[7:0];
        end
    end

    // pending commit, a new commit wins over the clear at a sample
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            commit_pend_reg <= 1'b0;
        end else if (wr_commit) begin
            commit_pend_reg <= 1'b1;
        end else if (smp_in_valid) begin
            commit_pend_reg <= 1'b0;
        end
    end

    // active values move only when a sample is taken
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            att_act_reg <= {6{dca_pkg::DCA_ATT_RESET}};
        end else if (smp_in_valid && commit_pend_reg) begin
            att_act_reg <= att_hold_reg;
        end
    end

    // the sample that takes a commit already uses the new values
    assign att_now = commit_pend_reg ? att_hold_reg : att_act_reg;

    // per-pair routing, sharing and attenuation
    genvar gp;
    generate
        for (gp = 0; gp < dca_pkg::DCA_PAIRS; gp++) begin : g_pair
            dca_pkg::dca_smp_t routed_l;
            dca_pkg::dca_smp_t routed_r;

            assign att_use[2*gp]   = att_now[2*gp];
            assign att_use[2*gp+1] = share_left ? att_now[2*gp] : att_now[2*gp+1];

            assign routed_l = route_pick(route_sel[1:0], smp_in[gp].left,
                                         smp_in[gp].right);
            assign routed_r = route_pick(route_sel[3:2], smp_in[gp].left,
                                         smp_in[gp].right);

            // attenuated frame is registered for the filter
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    out_frame_reg[gp] <= '0;
                end else if (smp_in_valid) begin
                    out_frame_reg[gp].left  <= att_apply(routed_l, att_use[2*gp]);
                    out_frame_reg[gp].right <= att_apply(routed_r, att_use[2*gp+1]);
                end
            end
        end
    endgenerate

    // output strobe follows the input strobe by one cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_reg <= 1'b0;
        end else begin
            out_valid_reg <= smp_in_valid;
        end
    end

    // readback, commit bit always zero, unmapped reads zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= 9'h000;
        end else if (rd_idx[3]) begin
            rd_data_reg <= {1'b0, att_hold_reg[rd_idx[2:0]]};
        end else if (reg_rd_addr == dca_pkg::DCA_ADDR_ATT_ALL) begin
            rd_data_reg <= {1'b0, att_all_reg};
        end else if (reg_rd_addr == dca_pkg::DCA_ADDR_CTRL) begin
            rd_data_reg <= ctrl_reg;
        end else begin
            rd_data_reg <= 9'h000;
        end
    end

    assign reg_rd_data   = rd_data_reg;
    assign smp_out_valid = out_valid_reg;
    assign smp_out       = out_frame_reg;

endmodule

`default_nettype wire

// ===== dca_mix_atten_monitor.sv
/* checker for the routing and attenuation block.
   bound to the routing and attenuation module, sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dca_mix_atten_monitor (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 arst_n,
    // register ports
    input wire logic                 reg_wr_en,
    input wire dca_pkg::dca_reg_wr_t reg_wr,
    input wire logic [6:0]           reg_rd_addr,
    input wire logic [8:0]           reg_rd_data,
    // sample ports
    input wire logic                 smp_in_valid,
    input wire dca_pkg::dca_frame_t  smp_in,
    input wire logic                 smp_out_valid,
    input wire dca_pkg::dca_frame_t  smp_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [8:0] ctl_reg;
    logic [7:0] h0_reg;
    // shadows of the control word and the first holding latch
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctl_reg <= 9'h120;
            h0_reg  <= 8'hFF;
        end else if (reg_wr_en) begin
            if (reg_wr.addr == 7'h02) ctl_reg <= reg_wr.data;
            if (reg_wr.addr == 7'h00 || reg_wr.addr == 7'h08) h0_reg <= reg_wr.data[7:0];
        end
    end
    property p_vld; smp_in_valid |=> smp_out_valid; endproperty
    property p_novld; !smp_in_valid |=> !smp_out_valid; endproperty
    property p_hold; !smp_out_valid |-> $stable(smp_out); endproperty
    property p_bit8; reg_rd_addr != 7'h02 |=> !reg_rd_data[8]; endproperty
    property p_unmap; reg_rd_addr == 7'h03 |=> reg_rd_data == 9'h000; endproperty
    property p_ctl; reg_rd_addr == 7'h02 |=> reg_rd_data == $past(ctl_reg); endproperty
    property p_h0; reg_rd_addr == 7'h00 |=> reg_rd_data == {1'b0, $past(h0_reg)}; endproperty
    property p_mute;
        smp_in_valid && ctl_reg[6:5] == 2'h0
        |=> {smp_out[0].left, smp_out[1].left, smp_out[2].left} == 72'h0;
    endproperty
    a_vld: assert property (p_vld) else $error("frame without output");
    a_novld: assert property (p_novld) else $error("spurious output");
    a_hold: assert property (p_hold) else $error("output moved idle");
    a_bit8: assert property (p_bit8) else $error("flag read back");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_ctl: assert property (p_ctl) else $error("control readback");
    a_h0: assert property (p_h0) else $error("holding readback");
    a_mute: assert property (p_mute) else $error("mute route");
    c_frm: cover property (smp_in_valid);
    c_upd: cover property (reg_wr_en && reg_wr.data[8]);
    c_all: cover property (reg_wr_en && reg_wr.addr == 7'h08);
endmodule
`default_nettype wire

// ===== dca_mix_atten_test.sv
/* self-checking bench for the routing and attenuation block.
   writes go through the host model; frames and reads are direct. */
`timescale 1ns/1ps
`default_nettype none
module dca_mix_atten_test;
    logic                 clk_sys = 1'b0;
    logic                 arst_n = 1'b0;
    logic                 reg_wr_en;
    dca_pkg::dca_reg_wr_t reg_wr;
    logic [6:0]           reg_rd_addr = 7'h00;
    logic [8:0]           reg_rd_data;
    logic                 smp_in_valid = 1'b0;
    dca_pkg::dca_frame_t  smp_in = '0;
    logic                 smp_out_valid;
    dca_pkg::dca_frame_t  smp_out;
    int                   n_mismatch = 0;
    int                   cmp_count = 0;
    logic [8:0]           ctl = 9'h120;
    logic [7:0]           hold [6] = '{default: 8'hFF};
    logic [7:0]           act [6] = '{default: 8'hFF};
    // overflowing sum, odd negative sum, extremes
    localparam dca_pkg::dca_frame_t F0 = {24'h800000, 24'h7FFFFF,
        24'hFFFFFB, 24'h000002, 24'h7FFFF0, 24'h000011};
    always #25 clk_sys = ~clk_sys;
    dca_host host (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_wr(reg_wr));
    dca_mix_atten dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
        .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
        .smp_in_valid(smp_in_valid), .smp_in(smp_in), .smp_out_valid(smp_out_valid),
        .smp_out(smp_out));
    task automatic chk(input logic [143:0] seen, input logic [143:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // source select, average at 25 bits
    function automatic logic [23:0] mix(input logic [1:0] s, input logic [23:0] l, r);
        logic [24:0] sum;
        sum = {l[23], l} + {r[23], r};
        return (s == 2'h0) ? 24'h0 : (s == 2'h1) ? l : (s == 2'h2) ? r : sum[24:1];
    endfunction
    // half-decibel steps, twelve per halving
    function automatic logic [23:0] att(input logic signed [23:0] x, input logic [7:0] c);
        int     n;
        longint p;
        n = 255 - c;
        p = longint'(x) * longint'(dca_pkg::DCA_STEP_GAIN[n % 12]);
        p = p >>> (15 + n / 12);
        return (c == 8'h00) ? 24'h0 : p[23:0];
    endfunction
    // send one frame, compare with the model
    task automatic frm();
        dca_pkg::dca_frame_t e;
        for (int g = 0; g < 3; g++) begin
            e[g].left = att(mix(ctl[6:5], F0[g].left, F0[g].right), act[2*g]);
            e[g].right = att(mix(ctl[8:7], F0[g].left, F0[g].right),
                ctl[3] ? act[2*g] : act[2*g+1]);
        end
        @(posedge clk_sys);
        smp_in_valid <= 1'b1;
        smp_in <= F0;
        @(posedge clk_sys);
        smp_in_valid <= 1'b0;
        smp_in <= ~F0;
        #1;
        chk(smp_out_valid, 1'b1);
        chk(smp_out, e);
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] x);
        @(posedge clk_sys);
        reg_rd_addr <= a;
        @(posedge clk_sys);
        #1;
        chk(reg_rd_data, x);
    endtask
    // write and track holding and active codes
    task automatic w(input logic [6:0] a, input logic [8:0] d);
        int i;
        i = (a < 7'h02) ? int'(a) : (a >= 7'h04 && a <= 7'h07) ? int'(a) - 2 : -1;
        host.wr(a, d);
        if (a == 7'h02) ctl = d;
        if (a == 7'h08) hold = '{default: d[7:0]};
        if (i >= 0) hold[i] = d[7:0];
        if (d[8] && (i >= 0 || a == 7'h08)) act = hold;
    endtask
    task automatic t_reset();
        for (int a = 0; a < 10; a++) begin
            rd(7'(a), a == 2 ? 9'h120 : (a == 3 || a == 9) ? 9'h0 : 9'h0FF);
        end
    endtask
    task automatic t_route();
        for (int r = 0; r < 16; r++) begin
            w(7'h02, {4'(r), 5'h00});
            frm();
        end
        w(7'h02, 9'h120);
    endtask
    task automatic t_latch();
        w(7'h00, 9'h0F3);
        rd(7'h00, 9'h0F3);
        frm();
        w(7'h01, 9'h1E7);
        frm();
        rd(7'h01, 9'h0E7);
    endtask
    task automatic t_master();
        w(7'h04, 9'h080);
        w(7'h08, 9'h100);
        rd(7'h04, 9'h000);
        rd(7'h08, 9'h000);
        frm();
    endtask
    task automatic t_codes();
        logic [7:0] cs [6] = '{8'h01, 8'h02, 8'h0C, 8'hF3, 8'hFE, 8'hFF};
        for (int k = 0; k < 6; k++) begin
            w(7'h08, {1'b1, cs[k]});
            frm();
        end
    endtask
    task automatic t_share();
        w(7'h02, 9'h128);
        w(7'h00, 9'h1E7);
        frm();
        w(7'h02, 9'h120);
        frm();
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // reset, then every scenario in turn
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset();
        t_route();
        t_latch();
        t_master();
        t_codes();
        t_share();
        results();
    end
endmodule
bind dca_mix_atten dca_mix_atten_monitor mon (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_wr_en(reg_wr_en), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .smp_in_valid(smp_in_valid), .smp_in(smp_in),
    .smp_out_valid(smp_out_valid), .smp_out(smp_out));
`default_nettype wire

// ===== dca_pkg.sv
/*
 * Shared constants and types for the six-channel routing and attenuation path:
 * register addresses, field positions, reset values, the fractional gain table
 * and the sample carriers.
 * Assumes a register write port with seven address bits and nine data bits.
 */
`default_nettype none

package dca_pkg;

    // widths and counts
    localparam int DCA_ADDR_W = 7;
    localparam int DCA_DATA_W = 9;
    localparam int DCA_SMP_W  = 24;
    localparam int DCA_ATT_W  = 8;
    localparam int DCA_PAIRS  = 3;
    localparam int DCA_CHANS  = 6;

    // register addresses
    localparam logic [6:0] DCA_ADDR_ATT_L0  = 7'h00;
    localparam logic [6:0] DCA_ADDR_ATT_R0  = 7'h01;
    localparam logic [6:0] DCA_ADDR_CTRL    = 7'h02;
    localparam logic [6:0] DCA_ADDR_ATT_L1  = 7'h04;
    localparam logic [6:0] DCA_ADDR_ATT_R1  = 7'h05;
    localparam logic [6:0] DCA_ADDR_ATT_L2  = 7'h06;
    localparam logic [6:0] DCA_ADDR_ATT_R2  = 7'h07;
    localparam logic [6:0] DCA_ADDR_ATT_ALL = 7'h08;

    // field positions
    localparam int DCA_COMMIT_BIT = 8;
    localparam int DCA_ROUTE_MSB  = 8;
    localparam int DCA_ROUTE_LSB  = 5;
    localparam int DCA_ATC_BIT    = 3;

    // reset values and special codes
    localparam logic [8:0] DCA_CTRL_RESET = 9'h120;
    localparam logic [7:0] DCA_ATT_RESET  = 8'hFF;
    localparam logic [7:0] DCA_ATT_MUTE   = 8'h00;

    // twelve half-decibel steps make one halving of the sample
    localparam logic [7:0] DCA_STEPS_PER_SHIFT = 8'h0C;
    localparam int         DCA_GAIN_FRAC       = 15;

    // gain of 0.5 dB steps 0..11 in unsigned Q1.15, index 0 is unity
    localparam logic [11:0][15:0] DCA_STEP_GAIN = {
        16'h43F4, 16'h47FB, 16'h4C3F, 16'h50C3, 16'h558C, 16'h5A9E,
        16'h5FFD, 16'h65AD, 16'h6BB3, 16'h7213, 16'h78D7, 16'h8000
    };

    // output source per side of a pair
    typedef enum logic [1:0] {
        DCA_ROUTE_MUTE  = 2'h0,
        DCA_ROUTE_LEFT  = 2'h1,
        DCA_ROUTE_RIGHT = 2'h2,
        DCA_ROUTE_AVG   = 2'h3
    } dca_route_t;

    typedef logic signed [23:0] dca_smp_t;
    typedef logic [7:0]         dca_att_t;

    typedef struct packed {
        dca_smp_t left;
        dca_smp_t right;
    } dca_pair_t;

    typedef dca_pair_t [2:0] dca_frame_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [8:0] data;
    } dca_reg_wr_t;

endpackage

`default_nettype wire
